// ---- pkg/get_pkg.sv ----
// Functional notes
// - Count events on A and B and offer five result functions.
// - Counts accumulate over gate openings until a clear command.
// - Running counts are shown continuously while the gate is open.
// - Function A: primary is A count, auxiliaries A minus B and A over B.
// - Function B: primary is B count, auxiliaries A minus B and A over B.
// - Sum function: primary A plus B, auxiliaries A and B.
// - Difference function: primary A minus B, auxiliaries A and B.
// - Ratio function: primary A over B, auxiliaries A and B.
// - Manual mode: each run/hold press toggles the gate; clear zeroes counts.
// - Manual mode offers no statistics, block or pacing.
// - Auto trigger levels are set once before the run, never during it.
// - Armed mode gates on A, B or E with chosen source, edge and delay.
// - Armed mode allows block arming; new result at each stop.
// - Gate opens after optional start delay of 10 ns to 2 s.
// - Stop source ignored for hold-off of 10 ns to 2 s after opening.
// - Timer stop closes gate after measurement time of 10 ns to 2 s.
// - Granularity selects arming per sample or once per block.
// - Start and stop edge polarity are independently rising or falling.
package get_pkg;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned DELAY_MIN_NS  = 10;
    localparam longint unsigned DELAY_MAX_NS = 64'h0000_0000_7735_9400;
    localparam int unsigned DELAY_MIN_CYC = (DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DELAY_MAX_CYC = int'(DELAY_MAX_NS / CLK_PERIOD_NS);
    localparam int unsigned DLY_W = 29;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned FRAC_W = 16;

    typedef enum logic [2:0]
    {
        GET_FN_A    = 3'h0,
        GET_FN_B    = 3'h1,
        GET_FN_SUM  = 3'h2,
        GET_FN_DIFF = 3'h3,
        GET_FN_RAT  = 3'h4
    } get_func_t;

    typedef enum logic [1:0]
    {
        GET_SRC_A = 2'h0,
        GET_SRC_B = 2'h1,
        GET_SRC_E = 2'h2,
        GET_SRC_T = 2'h3
    } get_src_t;

    typedef enum logic [4:0]
    {
        GET_ST_IDLE  = 5'b0_0001,
        GET_ST_WAIT  = 5'b0_0010,
        GET_ST_DLY   = 5'b0_0100,
        GET_ST_HOLD  = 5'b0_1000,
        GET_ST_OPEN  = 5'b1_0000
    } get_state_t;
endpackage

// ---- rtl/get_totalizer.sv ----
module get_totalizer
#(
    parameter int unsigned CW = get_pkg::CNT_W,
    parameter int unsigned DW = get_pkg::DLY_W
)
(
    // Clock and reset.
    input  wire logic                      sys_clk_i,
    input  wire logic                      reset_i,
    // Conditioned inputs.
    input  wire logic                      chan_a_i,
    input  wire logic                      chan_b_i,
    input  wire logic                      chan_e_i,
    // Control.
    input  wire logic                      clear_i,
    input  wire logic                      run_hold_i,
    input  wire logic                      armed_mode_i,
    input  wire logic                      arm_start_i,
    input  wire logic                      block_arm_i,
    input  wire logic                      block_done_i,
    input  wire logic                      auto_trig_i,
    input  wire get_pkg::get_func_t        func_i,
    input  wire get_pkg::get_src_t         start_src_i,
    input  wire get_pkg::get_src_t         stop_src_i,
    input  wire logic                      start_fall_i,
    input  wire logic                      stop_fall_i,
    input  wire logic [DW-1:0]             start_dly_i,
    input  wire logic [DW-1:0]             stop_dly_i,
    // Results.
    output logic                           gate_o,
    output logic [CW:0]                    primary_o,
    output logic [CW:0]                    aux1_o,
    output logic [CW:0]                    aux2_o,
    output logic                           ratio_invalid_o,
    output logic                           result_valid_o,
    output logic                           stats_allowed_o,
    output logic                           auto_level_req_o
);
    import get_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers and edge detection.
    logic [2:0] sync1_r, sync2_r, prev_r;
    logic [2:0] sync1_nxt, sync2_nxt, prev_nxt, rise, fall;
    logic       rh_prev_r, rh_prev_nxt, rh_edge;

    always_comb
    begin
        sync1_nxt   = {chan_e_i, chan_b_i, chan_a_i};
        sync2_nxt   = sync1_r;
        prev_nxt    = sync2_r;
        rise        = sync2_r & ~prev_r;
        fall        = ~sync2_r & prev_r;
        rh_prev_nxt = run_hold_i;
        rh_edge     = run_hold_i & ~rh_prev_r;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            sync1_r   <= 3'h0;
            sync2_r   <= 3'h0;
            prev_r    <= 3'h0;
            rh_prev_r <= 1'b0;
        end
        else
        begin
            sync1_r   <= sync1_nxt;
            sync2_r   <= sync2_nxt;
            prev_r    <= prev_nxt;
            rh_prev_r <= rh_prev_nxt;
        end
    end

    function automatic logic pick_edge(input get_src_t s, input logic falling,
                                       input logic [2:0] r, input logic [2:0] f);
        logic [2:0] e;
        e = falling ? f : r;
        unique case (s)
            GET_SRC_A: pick_edge = e[0];
            GET_SRC_B: pick_edge = e[1];
            GET_SRC_E: pick_edge = e[2];
            GET_SRC_T: pick_edge = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Gate control.
    get_state_t  st_r, st_nxt;
    logic [DW-1:0] tmr_r, tmr_nxt;
    logic        gate_r, gate_nxt, blk_open_r, blk_open_nxt;
    logic        rv_r, rv_nxt, lvl_r, lvl_nxt;
    logic        start_ev, stop_ev;
    logic [DW-1:0] sdly, hdly;

    always_comb
    begin
        start_ev     = pick_edge(start_src_i, start_fall_i, rise, fall);
        stop_ev      = pick_edge(stop_src_i, stop_fall_i, rise, fall);
        sdly         = (start_dly_i < DW'(DELAY_MIN_CYC)) ? DW'(DELAY_MIN_CYC) : start_dly_i;
        hdly         = (stop_dly_i < DW'(DELAY_MIN_CYC)) ? DW'(DELAY_MIN_CYC) : stop_dly_i;
        st_nxt       = st_r;
        tmr_nxt      = tmr_r;
        gate_nxt     = gate_r;
        blk_open_nxt = blk_open_r;
        rv_nxt       = 1'b0;
        lvl_nxt      = 1'b0;
        if (!armed_mode_i)
        begin
            st_nxt = GET_ST_IDLE;
            if (rh_edge)
            begin
                gate_nxt = ~gate_r;
                lvl_nxt  = ~gate_r & auto_trig_i;
            end
        end
        else
        begin
            if (block_done_i)
            begin
                blk_open_nxt = 1'b0;
            end
            unique case (st_r)
                GET_ST_IDLE:
                begin
                    gate_nxt = 1'b0;
                    if (arm_start_i)
                    begin
                        st_nxt  = GET_ST_WAIT;
                        lvl_nxt = auto_trig_i;
                    end
                end
                GET_ST_WAIT:
                begin
                    if (block_arm_i && blk_open_r)
                    begin
                        gate_nxt = 1'b1;
                        tmr_nxt  = hdly - DW'(1);
                        st_nxt   = GET_ST_HOLD;
                    end
                    else if (start_ev)
                    begin
                        tmr_nxt = sdly - DW'(1);
                        st_nxt  = GET_ST_DLY;
                    end
                end
                GET_ST_DLY:
                begin
                    if (tmr_r == '0)
                    begin
                        gate_nxt     = 1'b1;
                        blk_open_nxt = block_arm_i;
                        tmr_nxt      = hdly - DW'(1);
                        st_nxt       = GET_ST_HOLD;
                    end
                    else
                    begin
                        tmr_nxt = tmr_r - DW'(1);
                    end
                end
                GET_ST_HOLD:
                begin
                    if (tmr_r == '0)
                    begin
                        st_nxt = GET_ST_OPEN;
                    end
                    else
                    begin
                        tmr_nxt = tmr_r - DW'(1);
                    end
                    if (tmr_r == '0 && stop_src_i == GET_SRC_T)
                    begin
                        gate_nxt = 1'b0;
                        rv_nxt   = 1'b1;
                        st_nxt   = GET_ST_WAIT;
                    end
                end
                GET_ST_OPEN:
                begin
                    if (stop_ev)
                    begin
                        gate_nxt = 1'b0;
                        rv_nxt   = 1'b1;
                        st_nxt   = GET_ST_WAIT;
                    end
                end
                default:
                begin
                    st_nxt   = GET_ST_IDLE;
                    gate_nxt = 1'b0;
                end
            endcase
            if (!arm_start_i && st_r != GET_ST_IDLE)
            begin
                st_nxt   = GET_ST_IDLE;
                gate_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            st_r       <= GET_ST_IDLE;
            tmr_r      <= '0;
            gate_r     <= 1'b0;
            blk_open_r <= 1'b0;
            rv_r       <= 1'b0;
            lvl_r      <= 1'b0;
        end
        else
        begin
            st_r       <= st_nxt;
            tmr_r      <= tmr_nxt;
            gate_r     <= gate_nxt;
            blk_open_r <= blk_open_nxt;
            rv_r       <= rv_nxt;
            lvl_r      <= lvl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event counters.
    logic [CW-1:0] cnt_a_r, cnt_b_r, cnt_a_nxt, cnt_b_nxt;

    always_comb
    begin
        cnt_a_nxt = cnt_a_r;
        cnt_b_nxt = cnt_b_r;
        if (clear_i)
        begin
            cnt_a_nxt = '0;
            cnt_b_nxt = '0;
        end
        else if (gate_r)
        begin
            cnt_a_nxt = cnt_a_r + CW'(rise[0]);
            cnt_b_nxt = cnt_b_r + CW'(rise[1]);
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            cnt_a_r <= '0;
            cnt_b_r <= '0;
        end
        else
        begin
            cnt_a_r <= cnt_a_nxt;
            cnt_b_r <= cnt_b_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Result selection; ratio is fixed point with FRAC_W fraction bits.
    logic [CW:0] pri_r, a1_r, a2_r, pri_nxt, a1_nxt, a2_nxt;
    logic        inv_r, inv_nxt;
    logic [CW:0] sum, diff, ratio;
    logic [CW+FRAC_W-1:0] num;

    always_comb
    begin
        sum     = {1'b0, cnt_a_r} + {1'b0, cnt_b_r};
        diff    = {1'b0, cnt_a_r} - {1'b0, cnt_b_r};
        num     = {cnt_a_r, FRAC_W'(0)};
        inv_nxt = (cnt_b_r == '0);
        ratio   = inv_nxt ? '0 : (CW+1)'(num / (CW+FRAC_W)'(cnt_b_r));
        pri_nxt = '0;
        a1_nxt  = {1'b0, cnt_a_r};
        a2_nxt  = {1'b0, cnt_b_r};
        unique case (func_i)
            GET_FN_A:
            begin
                pri_nxt = {1'b0, cnt_a_r};
                a1_nxt  = diff;
                a2_nxt  = ratio;
            end
            GET_FN_B:
            begin
                pri_nxt = {1'b0, cnt_b_r};
                a1_nxt  = diff;
                a2_nxt  = ratio;
            end
            GET_FN_SUM:  pri_nxt = sum;
            GET_FN_DIFF: pri_nxt = diff;
            GET_FN_RAT:  pri_nxt = ratio;
            default:
            begin
                a1_nxt = '0;
                a2_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            pri_r <= '0;
            a1_r  <= '0;
            a2_r  <= '0;
            inv_r <= 1'b0;
        end
        else
        begin
            pri_r <= pri_nxt;
            a1_r  <= a1_nxt;
            a2_r  <= a2_nxt;
            inv_r <= inv_nxt;
        end
    end

    assign gate_o           = gate_r;
    assign primary_o        = pri_r;
    assign aux1_o           = a1_r;
    assign aux2_o           = a2_r;
    assign ratio_invalid_o  = inv_r;
    assign result_valid_o   = rv_r;
    assign stats_allowed_o  = armed_mode_i;
    assign auto_level_req_o = lvl_r;

endmodule // get_totalizer

// ---- tb/get_src_model.sv ----
module get_src_model
(
    // Clock.
    input  wire logic sys_clk_i,
    // Comparator outputs.
    output logic      chan_a_o,
    output logic      chan_b_o,
    output logic      chan_e_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {chan_a_o, chan_b_o, chan_e_o} = 3'h0;
    // Pulses are two cycles wide so the synchronisers cannot miss them.
    task automatic pulse(input int ch, input int n);
        repeat (n)
        begin
            @(negedge sys_clk_i);
            if (ch == 0) chan_a_o = 1'b1; else chan_b_o = 1'b1;
            repeat (2) @(negedge sys_clk_i);
            {chan_a_o, chan_b_o} = 2'h0;
            repeat (1) @(negedge sys_clk_i);
        end
    endtask
    task automatic set_e(input logic v);
        @(negedge sys_clk_i);
        chan_e_o = v;
    endtask
endmodule // get_src_model

// ---- tb/get_totalizer_sva.sv ----
module get_totalizer_sva
    import get_pkg::*;
#(
    parameter int unsigned CW = CNT_W,
    parameter int unsigned DW = DLY_W
)
(
    // Clock and reset.
    input  wire logic          sys_clk_i,
    input  wire logic          reset_i,
    // Control.
    input  wire logic          clear_i,
    input  wire logic          run_hold_i,
    input  wire logic          armed_mode_i,
    input  wire logic          arm_start_i,
    input  wire get_func_t     func_i,
    input  wire get_src_t      stop_src_i,
    input  wire logic [DW-1:0] stop_dly_i,
    // Results.
    input  wire logic          gate_o,
    input  wire logic [CW:0]   primary_o,
    input  wire logic [CW:0]   aux1_o,
    input  wire logic          ratio_invalid_o,
    input  wire logic          result_valid_o,
    input  wire logic          stats_allowed_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DW:0]   open_cnt_r;
    logic [DW:0]   open_cnt_nxt;
    logic [DW-1:0] hold_eff;
    assign hold_eff = (stop_dly_i < DW'(DELAY_MIN_CYC)) ? DW'(DELAY_MIN_CYC) : stop_dly_i;
    always_comb open_cnt_nxt = gate_o ? open_cnt_r + 1'b1 : '0;
    always_ff @(posedge sys_clk_i) open_cnt_r <= reset_i ? '0 : open_cnt_nxt;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////////////////////////////////////////////
    a_stats_mode: assert property (stats_allowed_o == armed_mode_i)
        else $error("stats permission differs from mode");
    a_closed_hold: assert property ((!gate_o && !clear_i && $stable(func_i))[*5]
        |-> $stable(primary_o)) else $error("result moved while gate closed");
    a_clear_zero: assert property (clear_i[*2] |=> aux1_o == '0 && ratio_invalid_o)
        else $error("clear did not zero counts");
    a_manual_toggle: assert property (!armed_mode_i && $rose(run_hold_i)
        |=> gate_o != $past(gate_o)) else $error("run hold did not toggle gate");
    a_hold_off: assert property (armed_mode_i && arm_start_i && $fell(gate_o)
        |-> open_cnt_r >= hold_eff) else $error("gate closed during hold-off");
    a_timer_bound: assert property (gate_o && armed_mode_i && arm_start_i
        && stop_src_i == GET_SRC_T |-> open_cnt_r < hold_eff) else $error("timed gate too long");
    a_stop_result: assert property (armed_mode_i && arm_start_i && $fell(gate_o)
        |-> ##[0:2] result_valid_o) else $error("no result at stop");
    a_valid_pulse: assert property (result_valid_o |=> !result_valid_o)
        else $error("result valid longer than one cycle");
    c_manual: cover property ($rose(gate_o) && !armed_mode_i);
    c_timer: cover property (result_valid_o && stop_src_i == GET_SRC_T);
    c_edge: cover property (result_valid_o && stop_src_i == GET_SRC_E);
endmodule // get_totalizer_sva

bind get_totalizer get_totalizer_sva #(.CW(CW), .DW(DW)) u_sva (.sys_clk_i, .reset_i,
    .clear_i, .run_hold_i, .armed_mode_i, .arm_start_i, .func_i, .stop_src_i, .stop_dly_i,
    .gate_o, .primary_o, .aux1_o, .ratio_invalid_o, .result_valid_o, .stats_allowed_o);

// ---- tb/get_totalizer_tb.sv ----
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module get_totalizer_tb
    import get_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 0, reset_i = 1, clear_i = 0, run_hold_i = 0, armed_mode_i = 0;
    logic arm_start_i = 0, block_arm_i = 0, block_done_i = 0, auto_trig_i = 0;
    logic start_fall_i = 0, stop_fall_i = 0, chan_a, chan_b, chan_e;
    get_func_t        func_i = GET_FN_A;
    get_src_t         start_src_i = GET_SRC_E, stop_src_i = GET_SRC_T;
    logic [DLY_W-1:0] start_dly_i = '0, stop_dly_i = '0;
    logic             gate_o, ratio_invalid_o, result_valid_o, stats_allowed_o, auto_level_req_o;
    logic [CNT_W:0]   primary_o, aux1_o, aux2_o;
    int               num_errors = 0, total_checks = 0, lvl_reqs = 0, valids = 0, n0, n1, n2;
    always #2.5 sys_clk_i = ~sys_clk_i;
    get_src_model src (.sys_clk_i, .chan_a_o(chan_a), .chan_b_o(chan_b), .chan_e_o(chan_e));
    get_totalizer DUT (.sys_clk_i, .reset_i, .chan_a_i(chan_a), .chan_b_i(chan_b),
        .chan_e_i(chan_e), .clear_i, .run_hold_i, .armed_mode_i, .arm_start_i, .block_arm_i,
        .block_done_i, .auto_trig_i, .func_i, .start_src_i, .stop_src_i, .start_fall_i,
        .stop_fall_i, .start_dly_i, .stop_dly_i, .gate_o, .primary_o, .aux1_o, .aux2_o,
        .ratio_invalid_o, .result_valid_o, .stats_allowed_o, .auto_level_req_o);
    always @(negedge sys_clk_i)
    begin
        if (auto_level_req_o === 1'b1) lvl_reqs++;
        if (result_valid_o === 1'b1) valids++;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic toggle();
        run_hold_i = 1;
        tick(2);
        run_hold_i = 0;
        tick(4);
    endtask
    task automatic check_res(input get_func_t f, input logic [CNT_W:0] p, a1, a2);
        func_i = f;
        tick(3);
        `CHK("primary", p, primary_o)
        `CHK("aux1", a1, aux1_o)
        `CHK("aux2", a2, aux2_o)
    endtask
    task automatic armed_open(input logic [DLY_W-1:0] sd, output int n);
        start_dly_i = sd;
        arm_start_i = 1;
        tick(2);
        src.set_e(1);
        n = 0;
        while (gate_o !== 1'b1 && n < 100)
        begin
            tick(1);
            n++;
        end
        if (n >= 100) num_errors++;
    endtask
    task automatic armed_close();
        tick(20);
        arm_start_i = 0;
        src.set_e(0);
        tick(3);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(5000);
        num_errors++;
        complete_run();
    end
    initial
    begin
        tick(4);
        reset_i = 0;
        tick(1);
        auto_trig_i = 1;
        toggle();
        auto_trig_i = 0;
        src.pulse(0, 6);
        src.pulse(1, 4);
        tick(4);
        `CHK("running", 33'h0_0000_0006, primary_o)
        `CHK("stats manual", 1'b0, stats_allowed_o)
        toggle();
        src.pulse(0, 3);
        tick(4);
        check_res(GET_FN_A, 33'h0_0000_0006, 33'h0_0000_0002, 33'h0_0001_8000);
        check_res(GET_FN_B, 33'h0_0000_0004, 33'h0_0000_0002, 33'h0_0001_8000);
        check_res(GET_FN_SUM, 33'h0_0000_000A, 33'h0_0000_0006, 33'h0_0000_0004);
        check_res(GET_FN_DIFF, 33'h0_0000_0002, 33'h0_0000_0006, 33'h0_0000_0004);
        check_res(GET_FN_RAT, 33'h0_0001_8000, 33'h0_0000_0006, 33'h0_0000_0004);
        `CHK("level requests", 1, lvl_reqs)
        toggle();
        src.pulse(0, 1);
        src.pulse(1, 5);
        tick(4);
        toggle();
        check_res(GET_FN_DIFF, 33'h1_FFFF_FFFE, 33'h0_0000_0007, 33'h0_0000_0009);
        check_res(GET_FN_RAT, 33'h0_0000_C71C, 33'h0_0000_0007, 33'h0_0000_0009);
        `CHK("ratio flag", 1'b0, ratio_invalid_o)
        clear_i = 1;
        tick(2);
        clear_i = 0;
        tick(3);
        check_res(GET_FN_SUM, '0, '0, '0);
        `CHK("ratio flag", 1'b1, ratio_invalid_o)
        armed_mode_i = 1;
        stop_dly_i = 10;
        armed_open(0, n0);
        armed_close();
        armed_open(2, n1);
        armed_close();
        armed_open(12, n2);
        armed_close();
        `CHK("short delay", n0, n1)
        `CHK("min delay", 3 + DELAY_MIN_CYC, n0)
        `CHK("start delay", n0 + 10, n2)
        stop_src_i = GET_SRC_E;
        stop_fall_i = 1;
        stop_dly_i = 40;
        armed_open(2, n0);
        tick(5);
        src.set_e(0);
        tick(50);
        `CHK("hold-off", 1'b1, gate_o)
        src.set_e(1);
        tick(2);
        src.set_e(0);
        tick(6);
        `CHK("falling stop", 1'b0, gate_o)
        arm_start_i = 0;
        tick(3);
        `CHK("results", 4, valids)
        stop_src_i = GET_SRC_T;
        stop_dly_i = 10;
        block_arm_i = 1;
        armed_open(2, n0);
        tick(24);
        `CHK("block rearm", 6, valids)
        block_done_i = 1;
        tick(1);
        block_done_i = 0;
        tick(20);
        `CHK("block end", 1'b0, gate_o)
        `CHK("block results", 7, valids)
        `CHK("stats armed", 1'b1, stats_allowed_o)
        arm_start_i = 0;
        block_arm_i = 0;
        complete_run();
    end
endmodule // get_totalizer_tb
